// ---- src/bap_regs.sv ----
// Bridge pin, secondary clock gate and system error cause registers
//
// Overview of operation
// - Output-clear ones drive bidirectional pins low
// - Output-set ones drive bidirectional pins high
// - Pin level changes cycle after write completes
// - Input-only pins are never driven
// - Zero writes keep bits; fields read last write
// - Enable-clear ones make pin input, tristated
// - Enable-set ones enable driver with stored data
// - Reserved pin field reads zero
// - Input field follows pin levels each clock
// - Clocks zero-three stop only when both ones
// - Clocks four-nine stop low on one
// - Top two clock gate bits read zero
// - Address parity error sets cause bit, W1C
// - Posted write data parity sets cause bit
// - Posted write non-delivery sets cause bit
// - Posted write target abort sets cause bit
// - Posted write master abort sets cause bit
// - Delayed write non-delivery sets cause bit
// - Delayed read without data sets cause bit
// - Master timeout on delayed repeat sets bit
// - Error asserts only if enabled and undisabled
`timescale 1ns/10ps
module bap_regs
	import bap_pkg::*;
#(
	parameter int GPIO_W = BAP_GPIO_W,
	parameter int CLK_COUNT = BAP_CLK_COUNT
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic [GPIO_W-1:0] gpio_in,
	output logic [GPIO_W-1:0] gpio_out,
	output logic [GPIO_W-1:0] gpio_oe,
	output logic [CLK_COUNT-1:0] secondary_clock_outputs,
	input wire logic [BAP_ERR_COUNT-1:0] error_events,
	input wire logic [BAP_ERR_COUNT-1:0] error_event_disable,
	input wire logic system_error_enable,
	output logic primary_system_error_out_n
);
	bap_cfg_state_t state;
	bap_cfg_state_t next_state;
	logic take;
	logic wr_gpio;
	logic wr_clk_err;
	logic [GPIO_W-1:0] out_clr_field;
	logic [GPIO_W-1:0] out_set_field;
	logic [GPIO_W-1:0] oe_clr_field;
	logic [GPIO_W-1:0] oe_set_field;
	logic [GPIO_W-1:0] out_data;
	logic [GPIO_W-1:0] out_enable;
	logic [GPIO_W-1:0] next_out_data;
	logic [GPIO_W-1:0] next_out_enable;
	logic [GPIO_W-1:0] pin_meta;
	logic [GPIO_W-1:0] pin_level;
	logic [BAP_CLK_FIELD_W-1:0] clk_gate;
	logic [CLK_COUNT-1:0] clk_run;
	logic [1:0] div_count;
	logic div_phase;
	logic [BAP_ERR_COUNT-1:0] err_clear;
	logic [BAP_ERR_COUNT-1:0] cause_events;
	logic [31:0] next_rdata;

	bap_err_if err ();

	// Byte lane of a field: ones written where the lane is enabled
	function automatic logic [3:0] lane_nibble(
		input logic [31:0] data,
		input logic [3:0] be,
		input int lsb
	);
		logic [3:0] nib;
		nib = data[lsb +: 4];
		if (!be[lsb / 8]) begin
			nib = 4'h0;
		end
		return nib;
	endfunction : lane_nibble

	// Register select, shared by the write strobes and the read mux
	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		return addr == offset;
	endfunction : addr_hit

	// Clock enable from its gate field
	function automatic logic clock_enabled(
		input logic [BAP_CLK_FIELD_W-1:0] gate,
		input int idx
	);
		logic en;
		if (idx < BAP_CLK_PAIR_COUNT) begin
			en = ~(gate[2 * idx] & gate[2 * idx + 1]);
		end else begin
			en = ~gate[BAP_CLK_SINGLE_LSB + idx - BAP_CLK_PAIR_COUNT];
		end
		return en;
	endfunction : clock_enabled

	// Configuration access: one answer cycle per request
	always_comb begin
		next_state = state;
		case (state)
			BAP_CFG_IDLE: begin
				if (cfg_req) begin
					next_state = BAP_CFG_ANSWER;
				end
			end
			BAP_CFG_ANSWER: begin
				next_state = BAP_CFG_IDLE;
			end
			default: begin
				next_state = BAP_CFG_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= BAP_CFG_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Requests arriving in the answer cycle are dropped, not queued
	assign take = cfg_req && (state == BAP_CFG_IDLE);
	assign cfg_ack = (state == BAP_CFG_ANSWER);

	always_comb begin
		wr_gpio = 1'b0;
		wr_clk_err = 1'b0;
		if (take && cfg_write && addr_hit(cfg_addr, BAP_GPIO_OFFSET)) begin
			wr_gpio = 1'b1;
		end else if (take && cfg_write
			&& addr_hit(cfg_addr, BAP_CLK_ERR_OFFSET)) begin
			wr_clk_err = 1'b1;
		end
	end

	// Stored write-one fields keep the last write to their byte lane
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_clr_field <= BAP_GPIO_RESET;
			out_set_field <= BAP_GPIO_RESET;
		end else if (wr_gpio && cfg_be[BAP_OUT_CLR_LSB / 8]) begin
			out_clr_field <= cfg_wdata[BAP_OUT_CLR_LSB +: 4];
			out_set_field <= cfg_wdata[BAP_OUT_SET_LSB +: 4];
		end
	end

	// Enable-field copies live in byte lane two
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			oe_clr_field <= BAP_GPIO_RESET;
			oe_set_field <= BAP_GPIO_RESET;
		end else if (wr_gpio && cfg_be[BAP_OE_CLR_LSB / 8]) begin
			oe_clr_field <= cfg_wdata[BAP_OE_CLR_LSB +: 4];
			oe_set_field <= cfg_wdata[BAP_OE_SET_LSB +: 4];
		end
	end

	// Set wins when set and clear name the same pin in one write
	always_comb begin
		next_out_data = out_data;
		next_out_enable = out_enable;
		if (wr_gpio) begin
			next_out_data = next_out_data
				& ~lane_nibble(cfg_wdata, cfg_be, BAP_OUT_CLR_LSB);
			next_out_data = next_out_data
				| lane_nibble(cfg_wdata, cfg_be, BAP_OUT_SET_LSB);
			next_out_enable = next_out_enable
				& ~lane_nibble(cfg_wdata, cfg_be, BAP_OE_CLR_LSB);
			next_out_enable = next_out_enable
				| lane_nibble(cfg_wdata, cfg_be, BAP_OE_SET_LSB);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_data <= BAP_GPIO_RESET;
			out_enable <= BAP_GPIO_RESET;
		end else begin
			out_data <= next_out_data;
			out_enable <= next_out_enable;
		end
	end

	// Extra pin stage so pins move on the cycle after completion
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_out <= BAP_GPIO_RESET;
		end else begin
			gpio_out <= out_data & out_enable;
		end
	end

	// Driver enable moves on the same edge as its data
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_oe <= BAP_GPIO_RESET;
		end else begin
			gpio_oe <= out_enable;
		end
	end

	// Pins are asynchronous, so two stages before the input field
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta <= BAP_GPIO_RESET;
			pin_level <= BAP_GPIO_RESET;
		end else begin
			pin_meta <= gpio_in;
			pin_level <= pin_meta;
		end
	end

	// Clock gate field, low byte lanes only
	// Bits 15:14 have no storage, so ones written there read back zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_gate <= BAP_CLK_GATE_RESET;
		end else if (wr_clk_err) begin
			if (cfg_be[0]) begin
				clk_gate[7:0] <= cfg_wdata[7:0];
			end
			if (cfg_be[1]) begin
				clk_gate[13:8] <= cfg_wdata[13:8];
			end
		end
	end

	// Secondary clock made by dividing the bus clock
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_count <= 2'h0;
			div_phase <= 1'b0;
		end else if (div_count == 2'(BAP_SCLK_HALF_CYCLES - 1)) begin
			div_count <= 2'h0;
			div_phase <= ~div_phase;
		end else begin
			div_count <= div_count + 2'h1;
		end
	end

	always_comb begin
		for (int i = 0; i < CLK_COUNT; i++) begin
			clk_run[i] = clock_enabled(clk_gate, i);
		end
	end

	// Stopped outputs are held low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			secondary_clock_outputs <= '0;
		end else begin
			secondary_clock_outputs <= clk_run & {CLK_COUNT{div_phase}};
		end
	end

	// Cause clear mask from the upper half of the shared word
	always_comb begin
		err_clear = '0;
		if (wr_clk_err && cfg_be[BAP_ERR_LSB / 8]) begin
			err_clear = cfg_wdata[BAP_ERR_LSB +: BAP_ERR_COUNT];
		end
	end

	// One detector input per status bit, in status bit order
	always_comb begin
		cause_events = '0;
		cause_events[BAP_ERR_ADDR_PARITY] =
			error_events[BAP_ERR_ADDR_PARITY];
		cause_events[BAP_ERR_PW_PARITY] =
			error_events[BAP_ERR_PW_PARITY];
		cause_events[BAP_ERR_PW_UNDELIVERED] =
			error_events[BAP_ERR_PW_UNDELIVERED];
		cause_events[BAP_ERR_PW_TARGET_ABORT] =
			error_events[BAP_ERR_PW_TARGET_ABORT];
		cause_events[BAP_ERR_PW_MASTER_ABORT] =
			error_events[BAP_ERR_PW_MASTER_ABORT];
		cause_events[BAP_ERR_DW_UNDELIVERED] =
			error_events[BAP_ERR_DW_UNDELIVERED];
		cause_events[BAP_ERR_DR_NO_DATA] =
			error_events[BAP_ERR_DR_NO_DATA];
		cause_events[BAP_ERR_MASTER_TIMEOUT] =
			error_events[BAP_ERR_MASTER_TIMEOUT];
	end

	assign err.events = cause_events;
	assign err.disables = error_event_disable;
	assign err.serr_enable = system_error_enable;
	assign err.clear_mask = err_clear;

	bap_err_cause u_err_cause (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.err(err)
	);

	// Registered so the error pin never shows decode glitches
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			primary_system_error_out_n <= 1'b1;
		end else begin
			primary_system_error_out_n <= ~err.serr_assert;
		end
	end

	// Read word, sampled at the taking edge; unmapped reads give zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (addr_hit(cfg_addr, BAP_GPIO_OFFSET)) begin
			next_rdata[BAP_OUT_CLR_LSB +: 4] = out_clr_field;
			next_rdata[BAP_OUT_SET_LSB +: 4] = out_set_field;
			next_rdata[BAP_OE_CLR_LSB +: 4] = oe_clr_field;
			next_rdata[BAP_OE_SET_LSB +: 4] = oe_set_field;
			next_rdata[BAP_GPIO_RSVD_LSB +: 4] = 4'h0;
			next_rdata[BAP_GPIO_IN_LSB +: 4] = pin_level;
		end else if (addr_hit(cfg_addr, BAP_CLK_ERR_OFFSET)) begin
			next_rdata[BAP_CLK_FIELD_W-1:0] = clk_gate;
			next_rdata[15:BAP_CLK_FIELD_W] = 2'b00;
			next_rdata[BAP_ERR_LSB +: BAP_ERR_COUNT] = err.status;
		end
	end

	// Read data holds until the next read is taken
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (take && !cfg_write) begin
			cfg_rdata <= next_rdata;
		end
	end
endmodule : bap_regs

// ---- src/bap_pkg.sv ----
// Package of offsets, field positions, reset values and states for the block
package bap_pkg;
	localparam logic [7:0] BAP_GPIO_OFFSET = 8'h64;
	localparam logic [7:0] BAP_CLK_ERR_OFFSET = 8'h68;
	localparam int BAP_GPIO_W = 4;
	localparam int BAP_OUT_CLR_LSB = 8;
	localparam int BAP_OUT_SET_LSB = 12;
	localparam int BAP_OE_CLR_LSB = 16;
	localparam int BAP_OE_SET_LSB = 20;
	localparam int BAP_GPIO_RSVD_LSB = 24;
	localparam int BAP_GPIO_IN_LSB = 28;
	localparam logic [3:0] BAP_GPIO_RESET = 4'h0;
	localparam int BAP_CLK_COUNT = 10;
	localparam int BAP_CLK_PAIR_COUNT = 4;
	localparam int BAP_CLK_SINGLE_LSB = 8;
	localparam int BAP_CLK_FIELD_W = 14;
	localparam logic [13:0] BAP_CLK_GATE_RESET = 14'h0000;
	localparam int BAP_ERR_LSB = 16;
	localparam int BAP_ERR_COUNT = 8;
	localparam logic [7:0] BAP_ERR_RESET = 8'h00;
	localparam int BAP_ERR_ADDR_PARITY = 0;
	localparam int BAP_ERR_PW_PARITY = 1;
	localparam int BAP_ERR_PW_UNDELIVERED = 2;
	localparam int BAP_ERR_PW_TARGET_ABORT = 3;
	localparam int BAP_ERR_PW_MASTER_ABORT = 4;
	localparam int BAP_ERR_DW_UNDELIVERED = 5;
	localparam int BAP_ERR_DR_NO_DATA = 6;
	localparam int BAP_ERR_MASTER_TIMEOUT = 7;
	localparam int BAP_SCLK_HALF_CYCLES = 2;
	typedef enum logic [1:0] {
		BAP_CFG_IDLE = 2'b01,
		BAP_CFG_ANSWER = 2'b10
	} bap_cfg_state_t;
endpackage : bap_pkg

// ---- src/bap_err_if.sv ----
// Interface between the register bank and the error cause recorder
`timescale 1ns/10ps
interface bap_err_if;
	import bap_pkg::*;
	logic [BAP_ERR_COUNT-1:0] events;
	logic [BAP_ERR_COUNT-1:0] disables;
	logic serr_enable;
	logic [BAP_ERR_COUNT-1:0] clear_mask;
	logic [BAP_ERR_COUNT-1:0] status;
	logic serr_assert;
	modport recorder (
		input events,
		input disables,
		input serr_enable,
		input clear_mask,
		output status,
		output serr_assert
	);
	modport bank (
		output events,
		output disables,
		output serr_enable,
		output clear_mask,
		input status,
		input serr_assert
	);
endinterface : bap_err_if

// ---- src/bap_err_cause.sv ----
// Recorder of system error causes with write-one-to-clear status
`timescale 1ns/10ps
module bap_err_cause
	import bap_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	bap_err_if.recorder err
);
	logic [BAP_ERR_COUNT-1:0] fire;
	logic [BAP_ERR_COUNT-1:0] status;
	logic serr_assert;

	// A cause counts only when not disabled and globally enabled
	always_comb begin
		fire = err.events & ~err.disables & {BAP_ERR_COUNT{err.serr_enable}};
	end

	// Set beats clear so an event in the clearing cycle is kept
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			status <= BAP_ERR_RESET;
		end else begin
			status <= (status & ~err.clear_mask) | fire;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serr_assert <= 1'b0;
		end else begin
			serr_assert <= |fire;
		end
	end

	assign err.status = status;
	assign err.serr_assert = serr_assert;
endmodule : bap_err_cause

// ---- bench/bap_regs_chk.sv ----
// Port assertions for the access handshake, pin and error registers
`timescale 1ns/10ps
module bap_regs_chk
	import bap_pkg::*;
#(
	parameter int GPIO_W = BAP_GPIO_W,
	parameter int CLK_COUNT = BAP_CLK_COUNT
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack,
	input wire logic [GPIO_W-1:0] gpio_out,
	input wire logic [GPIO_W-1:0] gpio_oe,
	input wire logic [BAP_ERR_COUNT-1:0] error_events,
	input wire logic [BAP_ERR_COUNT-1:0] error_event_disable,
	input wire logic system_error_enable,
	input wire logic primary_system_error_out_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic take, wr_pin, live;
	logic [3:0] set_on, clr_only, oe_on, oe_off;
	assign take = cfg_req && !cfg_ack;
	assign wr_pin = take && cfg_write && cfg_addr == BAP_GPIO_OFFSET;
	assign live = system_error_enable && |(error_events & ~error_event_disable);
	assign set_on = cfg_wdata[15:12];
	assign clr_only = cfg_wdata[11:8] & ~cfg_wdata[15:12];
	assign oe_on = cfg_wdata[23:20];
	assign oe_off = cfg_wdata[19:16] & ~cfg_wdata[23:20];
	property p_ack;
		take |=> cfg_ack ##1 !cfg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_set;
		wr_pin && cfg_be[1] |-> ##2
			(gpio_out & $past(set_on, 2)) == (gpio_oe & $past(set_on, 2));
	endproperty
	a_set: assert property (p_set) else $error("pin not set");
	property p_clr;
		wr_pin && cfg_be[1] |-> ##2 (gpio_out & $past(clr_only, 2)) == 4'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("pin not cleared");
	property p_oe;
		wr_pin && cfg_be[2] |-> ##2 (gpio_oe & $past(oe_off, 2)) == 4'h0
			&& (gpio_oe & $past(oe_on, 2)) == $past(oe_on, 2);
	endproperty
	a_oe: assert property (p_oe) else $error("enable wrong");
	property p_drive;
		(gpio_out & ~gpio_oe) == 4'h0;
	endproperty
	a_drive: assert property (p_drive) else $error("input pin driven");
	property p_rsvd;
		take && !cfg_write && cfg_addr == BAP_GPIO_OFFSET |=>
			cfg_rdata[27:24] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved nonzero");
	property p_err;
		live |-> ##2 !primary_system_error_out_n;
	endproperty
	a_err: assert property (p_err) else $error("error not raised");
	property p_noerr;
		!primary_system_error_out_n |-> $past(live, 2);
	endproperty
	a_noerr: assert property (p_noerr) else $error("stray error");
endmodule : bap_regs_chk

// ---- bench/bap_pin_board.sv ----
// Board side of the general pins
`timescale 1ns/10ps
module bap_pin_board (
	input wire logic [3:0] gpio_out,
	input wire logic [3:0] gpio_oe,
	input wire logic [3:0] board_level,
	output logic [3:0] gpio_in
);
	// Board drives only undriven pins, so no contention is modelled
	assign gpio_in = (gpio_out & gpio_oe) | (board_level & ~gpio_oe);
endmodule : bap_pin_board

// ---- bench/tb_top.sv ----
// Testbench for the pin, clock gate and error cause registers
`timescale 1ns/10ps
module tb_top;
	import bap_pkg::*;
	logic ref_clk = 1'h0, reset_n = 1'h0, cfg_req = 1'h0, cfg_write = 1'h0;
	logic [7:0] cfg_addr = 8'h00, ev = 8'h00, dis = 8'h00;
	logic [3:0] cfg_be = 4'h0, gpio_in, gpio_out, gpio_oe;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rd;
	logic cfg_ack, err_n, en = 1'h0;
	logic [9:0] sclk, hi, lo;
	int fails = 0, check_count = 0;
	always #2 ref_clk = ~ref_clk;
	bap_regs bap_regs_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .secondary_clock_outputs(sclk),
		.error_events(ev), .error_event_disable(dis),
		.system_error_enable(en), .primary_system_error_out_n(err_n));
	bap_pin_board bap_pin_board_i (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.board_level(4'hA), .gpio_in(gpio_in));
	task automatic end_of_test;
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(posedge ref_clk);
		cfg_req <= 1'h1;
		cfg_write <= w;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		// Held through the taking edge up to the edge that samples the answer
		repeat (2) @(posedge ref_clk);
		rd = cfg_rdata;
		chk("ack", 32'h1, {31'h0, cfg_ack});
		cfg_req <= 1'h0;
	endtask : acc
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		// Settle time covers the two-flop pin synchroniser
		repeat (3) @(posedge ref_clk);
		acc(1'h0, a, 4'hF, 32'h0);
		chk($sformatf("reg %h", a), e, rd);
	endtask : rdchk
	task automatic pins(input logic [3:0] o, input logic [3:0] oe);
		@(posedge ref_clk);
		#1 chk("gpio_out", {28'h0, o}, {28'h0, gpio_out});
		chk("gpio_oe", {28'h0, oe}, {28'h0, gpio_oe});
	endtask : pins
	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'h1;
		pins(4'h0, 4'h0);
		rdchk(BAP_GPIO_OFFSET, 32'hA0000000);
		rdchk(BAP_CLK_ERR_OFFSET, 32'h0);
		acc(1'h1, BAP_GPIO_OFFSET, 4'h6, 32'h00F03000);
		pins(4'h3, 4'hF);
		rdchk(BAP_GPIO_OFFSET, 32'h30F03000);
		acc(1'h1, BAP_GPIO_OFFSET, 4'h2, 32'h00000100);
		pins(4'h2, 4'hF);
		rdchk(BAP_GPIO_OFFSET, 32'h20F00100);
		acc(1'h1, BAP_GPIO_OFFSET, 4'h4, 32'h00020000);
		pins(4'h0, 4'hD);
		acc(1'h1, BAP_GPIO_OFFSET, 4'h4, 32'h00200000);
		pins(4'h2, 4'hF);
		acc(1'h1, 8'h70, 4'hF, 32'hFFFFFFFF);
		rdchk(8'h70, 32'h0);
		acc(1'h1, BAP_CLK_ERR_OFFSET, 4'h3, 32'h0000E1E7);
		repeat (2) @(posedge ref_clk);
		hi = 10'h000;
		lo = 10'h000;
		repeat (8) begin
			@(posedge ref_clk);
			#1 hi |= sclk;
			lo |= ~sclk;
		end
		chk("clock high", {22'h0, hi}, {22'h0, 10'h1E6});
		chk("clock low", {22'h0, lo}, {22'h0, 10'h3FF});
		rdchk(BAP_CLK_ERR_OFFSET, 32'h000021E7);
		en <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			for (int d = 1; d >= 0; d--) begin
				@(posedge ref_clk);
				ev <= 8'h01 << i;
				dis <= d ? 8'h01 << i : 8'h00;
				@(posedge ref_clk);
				ev <= 8'h00;
				@(posedge ref_clk);
				#1 chk("error out", {31'h0, 1'(d)}, {31'h0, err_n});
				@(posedge ref_clk);
				#1 chk("error pulse", 32'h1, {31'h0, err_n});
				if (d) rdchk(BAP_CLK_ERR_OFFSET, 32'h000021E7);
			end
			rdchk(BAP_CLK_ERR_OFFSET, 32'h21E7 | (32'h1 << (16 + i)));
			acc(1'h1, BAP_CLK_ERR_OFFSET, 4'h4, 32'h1 << (16 + i));
			rdchk(BAP_CLK_ERR_OFFSET, 32'h000021E7);
		end
		en <= 1'h0;
		ev <= 8'hFF;
		@(posedge ref_clk);
		ev <= 8'h00;
		@(posedge ref_clk);
		#1 chk("error masked", 32'h1, {31'h0, err_n});
		rdchk(BAP_CLK_ERR_OFFSET, 32'h000021E7);
		reset_n <= 1'h0;
		@(posedge ref_clk);
		reset_n <= 1'h1;
		pins(4'h0, 4'h0);
		rdchk(BAP_GPIO_OFFSET, 32'hA0000000);
		rdchk(BAP_CLK_ERR_OFFSET, 32'h0);
		end_of_test();
	end
	initial begin
		#40000;
		fails++;
		end_of_test();
	end
endmodule : tb_top
bind bap_regs bap_regs_chk #(.GPIO_W(GPIO_W), .CLK_COUNT(CLK_COUNT))
	bap_regs_chk_i (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_req(cfg_req),
	.cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe), .error_events(error_events),
	.error_event_disable(error_event_disable),
	.system_error_enable(system_error_enable),
	.primary_system_error_out_n(primary_system_error_out_n));
